// file: include/vic_pkg.sv
package vic_pkg;
    // register window
    localparam logic [31:0] BASE_ADDR      = 32'hffff_f000;
    localparam int          WINDOW_BITS    = 12;
    localparam int          NUM_SRC        = 32;
    localparam int          PRIO_W         = 3;
    localparam int          STACK_DEPTH    = 8;
    // byte offsets
    localparam logic [11:0] OFS_MODE_BASE  = 12'h000;
    localparam logic [11:0] OFS_MODE_LAST  = 12'h07c;
    localparam logic [11:0] OFS_VEC_BASE   = 12'h080;
    localparam logic [11:0] OFS_VEC_LAST   = 12'h0fc;
    localparam logic [11:0] OFS_CUR_VEC    = 12'h100;
    localparam logic [11:0] OFS_FAST_VEC   = 12'h104;
    localparam logic [11:0] OFS_CUR_ID     = 12'h108;
    localparam logic [11:0] OFS_PENDING    = 12'h10c;
    localparam logic [11:0] OFS_ENABLED    = 12'h110;
    localparam logic [11:0] OFS_CORE_STAT  = 12'h114;
    localparam logic [11:0] OFS_ENABLE_CMD = 12'h120;
    localparam logic [11:0] OFS_DISABLE_CMD= 12'h124;
    localparam logic [11:0] OFS_CLEAR_CMD  = 12'h128;
    localparam logic [11:0] OFS_SET_CMD    = 12'h12c;
    localparam logic [11:0] OFS_EOS_CMD    = 12'h130;
    localparam logic [11:0] OFS_SPURIOUS   = 12'h134;
    localparam logic [11:0] OFS_DEBUG      = 12'h138;
    localparam logic [11:0] OFS_FF_ENABLE  = 12'h140;
    localparam logic [11:0] OFS_FF_DISABLE = 12'h144;
    localparam logic [11:0] OFS_FF_STATUS  = 12'h148;
    // field layout
    localparam int          PRIO_LSB       = 0;
    localparam int          TRIG_EDGE_BIT  = 5;
    localparam int          MODE_TRIG_MSB  = 6;
    localparam logic [31:0] MODE_MASK      = 32'h0000_0067;
    localparam int          DBG_SAFE_BIT   = 0;
    localparam int          DBG_GMASK_BIT  = 1;
    localparam logic [31:0] DBG_MASK       = 32'h0000_0003;
    localparam int          CORE_FAST_BIT  = 0;
    localparam int          CORE_NORM_BIT  = 1;
    localparam int          ID_W           = 5;
    localparam int          FAST_SRC       = 0;
    localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
    // service state
    typedef enum logic [1:0] {
        VIC_IDLE_ST = 2'b01,
        VIC_BUSY_ST = 2'b10
    } vic_state_type;
endpackage

// file: src/vic_vec_mem.sv
`timescale 1ns/1ps
`default_nettype none
// handler address table, registered read port
module vic_vec_mem #(
    parameter int DEPTH = 32,
    parameter int AW    = 5,
    parameter int DW    = 32
) (
    // clock
    input  wire logic          mclk,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem_q [DEPTH];

    // contents cleared by the hardware reset sweep in vic_regs, not by software
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // registered read
    always_ff @(posedge mclk) begin
        rd_data <= mem_q[rd_addr];
    end
endmodule
`default_nettype wire

// file: src/vic_regs.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module vic_regs #(
    parameter int          NUM_SRC  = vic_pkg::NUM_SRC,
    parameter int          EXT_SRC  = 31,
    parameter logic [31:0] BASE     = vic_pkg::BASE_ADDR
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // interrupt sources, active high
    input  wire logic [31:0] src_in,
    // processor request lines, active low
    output logic             normal_request_line_n,
    output logic             fast_request_line_n
);
    // width of the current source number
    localparam int IDW = vic_pkg::ID_W;

    // decode: window hit and word offset
    logic        hit;
    logic [11:0] ofs;
    logic        wr_hit;
    logic        rd_hit;
    assign hit    = (reg_addr[31:vic_pkg::WINDOW_BITS] == BASE[31:vic_pkg::WINDOW_BITS]);
    assign ofs    = {reg_addr[11:2], 2'b00};
    assign wr_hit = reg_wr & hit;
    assign rd_hit = reg_rd & hit;

    // exact word offset match, shared by the single-register decodes
    function automatic logic is_ofs(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    // state
    logic [31:0]               mode_q [NUM_SRC];
    logic [31:0]               spurious_q;
    logic [31:0]               debug_q;
    logic [31:0]               enabled_q;
    logic [31:0]               pend_q;
    logic [31:0]               redirect_q;
    logic [31:0]               src_prev_q;
    logic [IDW-1:0]            cur_id_q;
    logic [vic_pkg::PRIO_W-1:0] cur_prio_q;
    logic [vic_pkg::PRIO_W-1:0] stack_q [vic_pkg::STACK_DEPTH];
    logic [3:0]                sp_q;
    logic [31:0]               vinit_q;
    logic                      vinit_done_q;
    vic_pkg::vic_state_type    state_q;

    // per-source trigger view
    logic [31:0] edge_mode;
    logic [31:0] level_view;
    logic [31:0] pending_view;
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_src
            if (g < NUM_SRC) begin : g_on
                assign edge_mode[g] = mode_q[g][vic_pkg::TRIG_EDGE_BIT];
            end else begin : g_off
                assign edge_mode[g] = 1'b0;
            end
            // level sources show the live input or the latch, edge sources the latch only
            assign pending_view[g] = edge_mode[g] ? pend_q[g] : (src_in[g] | pend_q[g]);
        end
    endgenerate
    assign level_view = src_in;

    // mode registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                mode_q[i] <= vic_pkg::RESET_WORD;
            end
        end else if (wr_hit && ofs <= vic_pkg::OFS_MODE_LAST) begin
            mode_q[ofs[6:2]] <= reg_wdata & vic_pkg::MODE_MASK;
        end
    end

    // vector memory: clears itself after reset, then software writes
    logic        vmem_we;
    logic [4:0]  vmem_waddr;
    logic [31:0] vmem_wdata;
    logic [4:0]  vmem_raddr;
    logic [31:0] vmem_rdata;
    logic        vec_sw_wr;
    assign vec_sw_wr  = wr_hit && ofs >= vic_pkg::OFS_VEC_BASE && ofs <= vic_pkg::OFS_VEC_LAST;
    assign vmem_we    = !vinit_done_q | vec_sw_wr;
    assign vmem_waddr = !vinit_done_q ? vinit_q[4:0] : ofs[6:2];
    assign vmem_wdata = !vinit_done_q ? vic_pkg::RESET_WORD : reg_wdata;

    // reset sweep of the vector table
    // software writes landing during the sweep may be lost
    always_ff @(posedge mclk) begin
        if (rst) begin
            vinit_q      <= vic_pkg::RESET_WORD;
            vinit_done_q <= 1'b0;
        end else if (!vinit_done_q) begin
            vinit_q      <= vinit_q + 32'h0000_0001;
            vinit_done_q <= (vinit_q[4:0] == 5'h1f);
        end
    end

    // priority resolution among enabled pending normal sources
    // strict compare: on a tie the lower source number wins
    logic [31:0]               cand;
    logic                      cand_any;
    logic [IDW-1:0]            best_id;
    logic [vic_pkg::PRIO_W-1:0] best_prio;
    logic                      fast_req;
    always_comb begin
        cand      = pending_view & enabled_q & ~redirect_q;
        cand[vic_pkg::FAST_SRC] = 1'b0;
        cand_any  = 1'b0;
        best_id   = '0;
        best_prio = '0;
        for (int i = 1; i < NUM_SRC; i++) begin
            if (cand[i] && (!cand_any ||
                mode_q[i][vic_pkg::PRIO_W-1:0] > best_prio)) begin
                cand_any  = 1'b1;
                best_id   = IDW'(i);
                best_prio = mode_q[i][vic_pkg::PRIO_W-1:0];
            end
        end
        fast_req = |(pending_view & enabled_q & (redirect_q | 32'h0000_0001));
    end

    // a candidate preempts only above the level being serviced
    logic preempt;
    assign preempt = cand_any && (state_q == vic_pkg::VIC_IDLE_ST || best_prio > cur_prio_q);

    // acknowledge event
    logic rd_cur;
    logic wr_cur;
    logic ack;
    logic eos;
    assign rd_cur = rd_hit && is_ofs(ofs, vic_pkg::OFS_CUR_VEC);
    assign wr_cur = wr_hit && is_ofs(ofs, vic_pkg::OFS_CUR_VEC);
    assign ack    = preempt && (debug_q[vic_pkg::DBG_SAFE_BIT] ? wr_cur : rd_cur);
    assign eos    = wr_hit && is_ofs(ofs, vic_pkg::OFS_EOS_CMD);

    // service context: current id, level and priority stack
    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_id_q   <= '0;
            cur_prio_q <= '0;
            sp_q       <= '0;
            state_q    <= vic_pkg::VIC_IDLE_ST;
            for (int i = 0; i < vic_pkg::STACK_DEPTH; i++) begin
                stack_q[i] <= '0;
            end
        end else if (ack) begin
            stack_q[sp_q[2:0]] <= cur_prio_q;
            sp_q       <= sp_q + 4'h1;
            cur_id_q   <= best_id;
            cur_prio_q <= best_prio;
            state_q    <= vic_pkg::VIC_BUSY_ST;
        end else if (eos && state_q == vic_pkg::VIC_BUSY_ST) begin
            sp_q       <= sp_q - 4'h1;
            cur_prio_q <= stack_q[sp_q[2:0] - 3'h1];
            state_q    <= (sp_q == 4'h1) ? vic_pkg::VIC_IDLE_ST : vic_pkg::VIC_BUSY_ST;
        end
    end

    // spurious and debug registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            spurious_q <= vic_pkg::RESET_WORD;
            debug_q    <= vic_pkg::RESET_WORD;
        end else if (wr_hit) begin
            if (is_ofs(ofs, vic_pkg::OFS_SPURIOUS)) begin
                spurious_q <= reg_wdata;
            end
            if (is_ofs(ofs, vic_pkg::OFS_DEBUG)) begin
                debug_q <= reg_wdata & vic_pkg::DBG_MASK;
            end
        end
    end

    // enable mask
    always_ff @(posedge mclk) begin
        if (rst) begin
            enabled_q <= vic_pkg::RESET_WORD;
        end else if (wr_hit && is_ofs(ofs, vic_pkg::OFS_ENABLE_CMD)) begin
            enabled_q <= enabled_q | reg_wdata;
        end else if (wr_hit && is_ofs(ofs, vic_pkg::OFS_DISABLE_CMD)) begin
            enabled_q <= enabled_q & ~reg_wdata;
        end
    end

    // fast redirect status
    always_ff @(posedge mclk) begin
        if (rst) begin
            redirect_q <= vic_pkg::RESET_WORD;
        end else if (wr_hit && is_ofs(ofs, vic_pkg::OFS_FF_ENABLE)) begin
            redirect_q <= redirect_q | reg_wdata;
        end else if (wr_hit && is_ofs(ofs, vic_pkg::OFS_FF_DISABLE)) begin
            redirect_q <= redirect_q & ~reg_wdata;
        end
    end

    // edge detection and pending latch; a new edge beats a clear
    logic [31:0] rise;
    logic [31:0] set_cmd;
    logic [31:0] clr_cmd;
    logic [31:0] ack_clr;
    assign rise    = level_view & ~src_prev_q & edge_mode;
    assign set_cmd = (wr_hit && is_ofs(ofs, vic_pkg::OFS_SET_CMD)) ? reg_wdata : '0;
    assign clr_cmd = (wr_hit && is_ofs(ofs, vic_pkg::OFS_CLEAR_CMD)) ? reg_wdata : '0;
    // acknowledging an edge source clears it; redirected ones stay
    assign ack_clr = ack ? (32'h0000_0001 << best_id) & edge_mode : '0;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pend_q     <= vic_pkg::RESET_WORD;
            src_prev_q <= vic_pkg::RESET_WORD;
        end else begin
            src_prev_q <= level_view;
            pend_q     <= (pend_q & ~clr_cmd & ~ack_clr) | rise | set_cmd;
        end
    end

    // request lines, registered and active low
    // the mask gates the lines only, pending state is kept
    always_ff @(posedge mclk) begin
        if (rst) begin
            normal_request_line_n <= 1'b1;
            fast_request_line_n   <= 1'b1;
        end else begin
            normal_request_line_n <= !(preempt && !debug_q[vic_pkg::DBG_GMASK_BIT]);
            fast_request_line_n   <= !(fast_req && !debug_q[vic_pkg::DBG_GMASK_BIT]);
        end
    end

    // vector memory read address chosen by what is being read
    assign vmem_raddr = is_ofs(ofs, vic_pkg::OFS_FAST_VEC) ? 5'h00 :
                        is_ofs(ofs, vic_pkg::OFS_CUR_VEC)  ? best_id : ofs[6:2];

    vic_vec_mem #(
        .DEPTH (32),
        .AW    (5),
        .DW    (32)
    ) i_vic_vec_mem (
        .mclk    (mclk),
        .wr_en   (vmem_we),
        .wr_addr (vmem_waddr),
        .wr_data (vmem_wdata),
        .rd_addr (vmem_raddr),
        .rd_data (vmem_rdata)
    );

    // read selection captured alongside the memory read
    typedef enum logic [2:0] {
        VIC_SEL_REG_TYPE = 3'b001,
        VIC_SEL_MEM_TYPE = 3'b010,
        VIC_SEL_SPU_TYPE = 3'b100
    } vic_rsel_type;
    vic_rsel_type rsel_q;
    logic [31:0]  rword_q;
    logic [31:0]  rword_d;
    vic_rsel_type rsel_d;
    always_comb begin
        rword_d = vic_pkg::RESET_WORD;
        rsel_d  = VIC_SEL_REG_TYPE;
        if (rd_hit) begin
            if (ofs <= vic_pkg::OFS_MODE_LAST) begin
                rword_d = mode_q[ofs[6:2]];
            end else if (ofs <= vic_pkg::OFS_VEC_LAST) begin
                rsel_d = VIC_SEL_MEM_TYPE;
            end else if (is_ofs(ofs, vic_pkg::OFS_CUR_VEC)) begin
                rsel_d = preempt ? VIC_SEL_MEM_TYPE : VIC_SEL_SPU_TYPE;
            end else if (is_ofs(ofs, vic_pkg::OFS_FAST_VEC)) begin
                rsel_d = fast_req ? VIC_SEL_MEM_TYPE : VIC_SEL_SPU_TYPE;
            end else if (is_ofs(ofs, vic_pkg::OFS_CUR_ID)) begin
                rword_d = {27'h0, cur_id_q};
            end else if (is_ofs(ofs, vic_pkg::OFS_PENDING)) begin
                rword_d = pending_view;
            end else if (is_ofs(ofs, vic_pkg::OFS_ENABLED)) begin
                rword_d = enabled_q;
            end else if (is_ofs(ofs, vic_pkg::OFS_CORE_STAT)) begin
                rword_d = {30'h0, !normal_request_line_n, !fast_request_line_n};
            end else if (is_ofs(ofs, vic_pkg::OFS_SPURIOUS)) begin
                rword_d = spurious_q;
            end else if (is_ofs(ofs, vic_pkg::OFS_DEBUG)) begin
                rword_d = debug_q;
            end else if (is_ofs(ofs, vic_pkg::OFS_FF_STATUS)) begin
                rword_d = redirect_q;
            end
        end
    end

    // capture selection; spurious value taken at request time
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsel_q  <= VIC_SEL_REG_TYPE;
            rword_q <= vic_pkg::RESET_WORD;
        end else begin
            rsel_q  <= rsel_d;
            rword_q <= (rsel_d == VIC_SEL_SPU_TYPE) ? spurious_q : rword_d;
        end
    end

    // read data: registered word or registered memory output
    // both arms and the select are flops, so no decode glitch reaches the pins
    always_comb begin
        case (rsel_q)
            VIC_SEL_MEM_TYPE: reg_rdata = vmem_rdata;
            VIC_SEL_REG_TYPE: reg_rdata = rword_q;
            VIC_SEL_SPU_TYPE: reg_rdata = rword_q;
            default:          reg_rdata = vic_pkg::RESET_WORD;
        endcase
    end
endmodule
`default_nettype wire

// file: dv/vic_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// port checker for the register block
module vic_regs_props #(
    parameter logic [31:0] BASE = vic_pkg::BASE_ADDR
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // sources and request lines
    input wire logic [31:0] src_in,
    input wire logic        normal_request_line_n,
    input wire logic        fast_request_line_n
);
    logic        win;
    logic        rdw;
    logic [11:0] ofs;
    logic [1:0]  dbg_q;
    logic [31:0] spu_q;
    logic [31:0] vec0_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // decode of the accessed word
    assign win = reg_addr[31:12] == BASE[31:12];
    assign rdw = reg_rd && win;
    assign ofs = {reg_addr[11:2], 2'b00};
    // shadows of the plain read/write registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            dbg_q  <= 2'b00;
            spu_q  <= 32'h0000_0000;
            vec0_q <= 32'h0000_0000;
        end else if (reg_wr && win) begin
            if (ofs == vic_pkg::OFS_DEBUG) dbg_q <= reg_wdata[1:0];
            if (ofs == vic_pkg::OFS_SPURIOUS) spu_q <= reg_wdata;
            if (ofs == vic_pkg::OFS_VEC_BASE) vec0_q <= reg_wdata;
        end
    end
    a_outside_zero: assert property (reg_rd && !win |=> reg_rdata == 32'h0000_0000)
        else $error("read outside window not zero");
    a_wo_read_zero: assert property (rdw && ofs inside {12'h118, 12'h11c, 12'h120, 12'h124, 12'h128,
        12'h12c, 12'h130, 12'h13c, 12'h140, 12'h144} |=> reg_rdata == 32'h0000_0000)
        else $error("write-only or reserved read not zero");
    a_mode_fields_only: assert property (rdw && ofs <= vic_pkg::OFS_MODE_LAST
        |=> (reg_rdata & ~vic_pkg::MODE_MASK) == 32'h0000_0000)
        else $error("mode register unused bits set");
    a_id_upper_zero: assert property (rdw && ofs == vic_pkg::OFS_CUR_ID |=> reg_rdata[31:5] == '0)
        else $error("source number upper bits set");
    a_core_upper_zero: assert property (rdw && ofs == vic_pkg::OFS_CORE_STAT |=> reg_rdata[31:2] == '0)
        else $error("core status upper bits set");
    a_debug_readback: assert property (rdw && ofs == vic_pkg::OFS_DEBUG |=> reg_rdata == {30'h0000_0000, dbg_q})
        else $error("debug register readback wrong");
    a_spur_readback: assert property (rdw && ofs == vic_pkg::OFS_SPURIOUS |=> reg_rdata == spu_q)
        else $error("spurious register readback wrong");
    a_fast_vec_source: assert property (rdw && ofs == vic_pkg::OFS_FAST_VEC
        |=> reg_rdata == vec0_q || reg_rdata == spu_q)
        else $error("fast vector neither entry zero nor spurious");
    a_gmask_lines_off: assert property (dbg_q[1] |=> normal_request_line_n && fast_request_line_n)
        else $error("request line active under global mask");
endmodule
bind vic_regs vic_regs_props #(.BASE(BASE)) i_vic_regs_props (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_in(src_in),
    .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n));
`default_nettype wire

// file: dv/vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// processor side: samples both request lines
module vic_core_model (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // request lines, active low
    input  wire logic normal_request_line_n,
    input  wire logic fast_request_line_n,
    // observation
    input  wire logic clr_seen,
    output logic      normal_seen,
    output logic      fast_seen
);
    // remembers any request since the last clear
    always_ff @(posedge mclk) begin
        if (rst || clr_seen) begin
            normal_seen <= 1'b0;
            fast_seen   <= 1'b0;
        end else begin
            if (!normal_request_line_n) normal_seen <= 1'b1;
            if (!fast_request_line_n) fast_seen <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [31:0] B = vic_pkg::BASE_ADDR;
    logic        mclk;
    logic        rst;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] src_in;
    logic        normal_request_line_n;
    logic        fast_request_line_n;
    logic        clr_seen;
    logic        normal_seen;
    logic        fast_seen;
    int          miscompares;
    int          total_checks;
    int          cyc;
    vic_regs i_vic_regs (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_in(src_in),
        .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n));
    vic_core_model i_vic_core_model (.mclk(mclk), .rst(rst), .normal_request_line_n(normal_request_line_n),
        .fast_request_line_n(fast_request_line_n), .clr_seen(clr_seen), .normal_seen(normal_seen),
        .fast_seen(fast_seen));
    // clock and hang guard
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            conclude;
        end
    end
    task automatic conclude;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // bus cycles, full address and window offset
    task automatic wra(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] o, input logic [31:0] d);
        wra({B[31:12], o}, d);
    endtask
    task automatic rda(input logic [31:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask
    task automatic rd(input logic [11:0] o, input logic [31:0] e);
        rda({B[31:12], o}, e);
    endtask
    // clears the core flags, then waits a bounded time for a request
    task automatic wait_seen(input logic fast, input logic exp);
        clr_seen <= 1'b1;
        @(posedge mclk);
        clr_seen <= 1'b0;
        // flags are sticky, so look once after the whole window
        repeat (12) @(posedge mclk);
        #1 check({31'h0000_0000, fast ? fast_seen : normal_seen}, {31'h0000_0000, exp});
    endtask
    task automatic t_reset_vals;
        logic [11:0] lst [14] = '{12'h000, 12'h07c, 12'h080, 12'h0fc, 12'h108, 12'h10c, 12'h110,
                                 12'h114, 12'h118, 12'h120, 12'h130, 12'h134, 12'h138, 12'h148};
        foreach (lst[i]) rd(lst[i], 32'h0000_0000);
    endtask
    task automatic t_map;
        wr(12'h014, 32'hffff_ffff);
        rd(12'h014, vic_pkg::MODE_MASK);
        wr(12'h014, 32'h0000_0000);
        wr(12'h0fc, 32'h1234_5678);
        rd(12'h0fc, 32'h1234_5678);
        wr(12'h134, 32'h5a5a_0000);
        wra(32'h0000_0134, 32'h0000_ffff);
        rd(12'h134, 32'h5a5a_0000);
        rda(32'h0000_0134, 32'h0000_0000);
        wr(12'h10c, 32'hffff_ffff);
        rd(12'h10c, 32'h0000_0000);
    endtask
    task automatic t_safe;
        wr(12'h09c, 32'h0000_0700);
        wr(12'h01c, 32'h0000_0005);
        wr(12'h138, 32'h0000_0001);
        wr(12'h120, 32'h0000_0080);
        src_in[7] <= 1'b1;
        wait_seen(1'b0, 1'b1);
        rd(12'h100, 32'h0000_0700);
        rd(12'h108, 32'h0000_0000);
        wr(12'h100, 32'h0000_0000);
        rd(12'h108, 32'h0000_0007);
        wr(12'h130, 32'h0000_0000);
        wr(12'h138, 32'h0000_0000);
    endtask
    task automatic t_prio;
        wr(12'h08c, 32'h0000_0300);
        wr(12'h00c, 32'h0000_0002);
        wr(12'h120, 32'h0000_0008);
        rd(12'h110, 32'h0000_0088);
        src_in[3] <= 1'b1;
        wait_seen(1'b0, 1'b1);
        rd(12'h100, 32'h0000_0700);
        rd(12'h108, 32'h0000_0007);
        wr(12'h130, 32'hffff_ffff);
        src_in[7] <= 1'b0;
        wait_seen(1'b0, 1'b1);
        rd(12'h100, 32'h0000_0300);
        rd(12'h108, 32'h0000_0003);
        wr(12'h130, 32'h0000_0000);
        src_in[3] <= 1'b0;
        rd(12'h10c, 32'h0000_0000);
        rd(12'h100, 32'h5a5a_0000);
        wr(12'h130, 32'h0000_0000);
        wr(12'h124, 32'h0000_0088);
        rd(12'h110, 32'h0000_0000);
    endtask
    task automatic t_fast;
        wr(12'h080, 32'hf000_0000);
        wr(12'h120, 32'h0000_0001);
        wr(12'h12c, 32'h0000_0001);
        wait_seen(1'b1, 1'b1);
        rd(12'h10c, 32'h0000_0001);
        rd(12'h104, 32'hf000_0000);
        wr(12'h138, 32'h0000_0002);
        wait_seen(1'b1, 1'b0);
        rd(12'h138, 32'h0000_0002);
        wr(12'h138, 32'h0000_0000);
        wr(12'h128, 32'h0000_0001);
        rd(12'h10c, 32'h0000_0000);
        rd(12'h104, 32'h5a5a_0000);
        wr(12'h124, 32'h0000_0001);
    endtask
    task automatic t_redirect;
        wr(12'h140, 32'h0000_0030);
        wr(12'h144, 32'h0000_0010);
        rd(12'h148, 32'h0000_0020);
        wr(12'h144, 32'h0000_0020);
        rd(12'h148, 32'h0000_0000);
    endtask
    // edge source latch and ack clear, then the same source redirected to fast
    task automatic t_edge;
        wr(12'h090, 32'h0000_0400);
        wr(12'h010, 32'h0000_0023);
        wr(12'h120, 32'h0000_0010);
        src_in[4] <= 1'b1;
        @(posedge mclk);
        src_in[4] <= 1'b0;
        rd(12'h10c, 32'h0000_0010);
        rd(12'h100, 32'h0000_0400);
        rd(12'h10c, 32'h0000_0000);
        wr(12'h130, 32'h0000_0000);
        wr(12'h140, 32'h0000_0010);
        wr(12'h12c, 32'h0000_0010);
        wait_seen(1'b1, 1'b1);
        rd(12'h100, 32'h5a5a_0000);
        rd(12'h10c, 32'h0000_0010);
        rd(12'h104, 32'hf000_0000);
        rd(12'h114, 32'h0000_0001);
        wr(12'h128, 32'h0000_0010);
        wr(12'h144, 32'h0000_0010);
        wr(12'h124, 32'h0000_0010);
    endtask
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        src_in = '0;
        clr_seen = 1'b0;
        miscompares = 0;
        total_checks = 0;
        cyc = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (34) @(posedge mclk);
        t_reset_vals;
        t_map;
        t_safe;
        t_prio;
        t_fast;
        t_redirect;
        t_edge;
        conclude;
    end
endmodule
`default_nettype wire
